// File: speed_match_pkg.sv
package speed_match_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int DIV_W = 16;
    localparam int DATA_BITS = 8;

    // ------------------------------------------------------------
    // register addresses (read and write spaces are separate)
    // ------------------------------------------------------------
    localparam logic [3:0] WR_TXDATA = 4'h0;
    localparam logic [3:0] WR_TEST = 4'h2;
    localparam logic [3:0] WR_MODE = 4'h4;
    localparam logic [3:0] WR_IRQSEL = 4'h5;
    localparam logic [3:0] WR_DIVLO = 4'h6;
    localparam logic [3:0] WR_DIVHI = 4'h7;
    localparam logic [3:0] RR_RXDATA = 4'h0;
    localparam logic [3:0] RR_STATUS = 4'h1;
    localparam logic [3:0] RR_ERROR = 4'h2;
    localparam logic [3:0] RR_DIVLO = 4'h3;
    localparam logic [3:0] RR_DIVHI = 4'h4;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int B_TEST_A = 0;
    localparam int B_SMEN = 3;
    localparam int B_ABORT = 5;
    localparam int B_SEL_LO = 3;
    localparam int B_BRK_IRQ = 6;

    // ------------------------------------------------------------
    // reset values, selections and timing
    // ------------------------------------------------------------
    localparam logic [DIV_W-1:0] DIV_RESET = 16'h0001;
    localparam logic [2:0] SEL_SPEED = 3'h0;
    localparam logic [CNT_W-1:0] LOAD_MIN = 16'h0048;
    localparam int DIV_SHIFT = 4;
    localparam logic [3:0] PH_MID = 4'h8;
    localparam logic [3:0] PH_LAST = 4'hF;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] TX_LAST = 4'h9;

    // estimate of the divisor from a low-pulse length
    function automatic logic [DIV_W-1:0] count_to_div(input logic [CNT_W-1:0] c);
        return c >> DIV_SHIFT;
    endfunction : count_to_div

endpackage : speed_match_pkg

// File: rx_low_timer.sv
`timescale 1ns/100ps
module rx_low_timer
    import speed_match_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic rx_pin,
    output logic rx_level,
    output logic rx_fall,
    output logic rx_rise,
    output logic [CNT_W-1:0] low_count
);

    logic sync1;
    logic sync2;

    // ------------------------------------------------------------
    // pin synchroniser, third flop keeps the last level
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            rx_level <= 1'b1;
        end else begin
            sync1 <= rx_pin;
            sync2 <= sync1;
            rx_level <= sync2;
        end
    end

    // edge pulses line up with the new level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_fall <= 1'b0;
            rx_rise <= 1'b0;
        end else begin
            rx_fall <= rx_level & ~sync2;
            rx_rise <= ~rx_level & sync2;
        end
    end

    // ------------------------------------------------------------
    // low-time counter, saturates so a stuck line cannot wrap
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_count <= '0;
        end else if (rx_level && !sync2) begin
            low_count <= CNT_W'(1);
        end else if (!rx_level && !sync2 && low_count != '1) begin
            low_count <= low_count + CNT_W'(1);
        end
    end

endmodule : rx_low_timer

// File: uart_speed_match.sv
`timescale 1ns/100ps
// Notes on behaviour
// - receive falling edge clears enable bit
// - good pulse loads divisor estimate, used
// - divisor readable once line goes high
// - selection 000 raises latched interrupt
// - latched interrupt cleared by writing zero
// - overlong low pulse declares a break
// - break leaves divisor, raises interrupt only if enabled
// - short pulse still loads useless divisor
// - zero divisor halts transmitter and receiver
// - outputs released during reset
// - reset empties data, clears status, controls
// - eight-bit host bus with chip select
// - break flag cleared only by received one
// - interrupt pin held low one cycle minimum
module uart_speed_match
    import speed_match_pkg::*;
#(
    parameter logic [CNT_W-1:0] BREAK_LIMIT = 16'h8008
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic chip_sel,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_oe,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic tx_pin_oe,
    output logic receive_interrupt_output_n,
    output logic receive_interrupt_output_oe
);

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BRK_WAIT} rx_state_t;

    logic rx_level, rx_fall, rx_rise;
    logic [CNT_W-1:0] low_count;
    logic wr_ok, rd_ok, tick;
    logic speed_match_enable, transmit_abort, test_a, brk_irq_en;
    logic [2:0] irq_sel;
    logic meas, good_end, brk_hit;
    logic [DIV_W-1:0] divisor, baud_cnt;
    logic sm_irq, rx_pend, break_detected_flag, frame_err, short_pulse;
    rx_state_t rx_state;
    logic [3:0] rx_ph;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh, rx_data;
    logic rx_full, rx_done, tx_full, tx_busy;
    logic [7:0] tx_hold;
    logic [9:0] tx_sh;
    logic [3:0] tx_ph, tx_cnt;

    rx_low_timer u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rx_pin(rx_pin),
        .rx_level(rx_level),
        .rx_fall(rx_fall),
        .rx_rise(rx_rise),
        .low_count(low_count)
    );

    // ------------------------------------------------------------
    // host access
    // ------------------------------------------------------------
    assign wr_ok = reg_wr & chip_sel;
    assign rd_ok = reg_rd & chip_sel;
    assign good_end = meas & rx_rise;
    assign brk_hit = meas & ~rx_level & (low_count > BREAK_LIMIT);

    // mode bits; the line edge beats a same-cycle write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            speed_match_enable <= 1'b0;
            transmit_abort <= 1'b0;
        end else begin
            if (wr_ok && reg_addr == WR_MODE) begin
                transmit_abort <= reg_wdata[B_ABORT];
                speed_match_enable <= reg_wdata[B_SMEN];
            end
            if (rx_fall) begin
                speed_match_enable <= 1'b0;
            end
        end
    end

    // remaining control bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            test_a <= 1'b0;
            irq_sel <= SEL_SPEED;
            brk_irq_en <= 1'b0;
        end else if (wr_ok && reg_addr == WR_TEST) begin
            test_a <= reg_wdata[B_TEST_A];
        end else if (wr_ok && reg_addr == WR_IRQSEL) begin
            irq_sel <= reg_wdata[B_SEL_LO +: 3];
            brk_irq_en <= reg_wdata[B_BRK_IRQ];
        end
    end

    // ------------------------------------------------------------
    // measurement of the first low pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meas <= 1'b0;
        end else if (rx_fall && speed_match_enable) begin
            meas <= 1'b1;
        end else if (rx_rise || brk_hit) begin
            meas <= 1'b0;
        end
    end

    // divisor: measured load wins over a host write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divisor <= DIV_RESET;
        end else if (good_end) begin
            divisor <= count_to_div(low_count);
        end else if (wr_ok && reg_addr == WR_DIVLO) begin
            divisor[7:0] <= reg_wdata;
        end else if (wr_ok && reg_addr == WR_DIVHI) begin
            divisor[15:8] <= reg_wdata;
        end
    end

    // short pulse marks a useless estimate
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            short_pulse <= 1'b0;
        end else if (good_end) begin
            short_pulse <= (low_count < LOAD_MIN);
        end
    end

    // latched speed-match interrupt, set wins over clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sm_irq <= 1'b0;
        end else if (good_end && irq_sel == SEL_SPEED) begin
            sm_irq <= 1'b1;
        end else if (wr_ok && reg_addr == WR_MODE && !reg_wdata[B_SMEN]) begin
            sm_irq <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // baud generator, 16 ticks per bit
    // ------------------------------------------------------------
    assign tick = (divisor != '0) && (baud_cnt == divisor - DIV_W'(1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            baud_cnt <= '0;
        end else if (good_end || tick || divisor == '0) begin
            baud_cnt <= '0; // phase restarts on a fresh estimate
        end else begin
            baud_cnt <= baud_cnt + DIV_W'(1);
        end
    end

    // ------------------------------------------------------------
    // receiver; after a match the start bit is already spent
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= RX_IDLE;
            rx_ph <= '0;
            rx_bit <= '0;
            rx_sh <= '0;
        end else if (good_end) begin
            rx_state <= RX_DATA;
            rx_ph <= '0;
            rx_bit <= '0;
        end else if (brk_hit) begin
            rx_state <= RX_BRK_WAIT;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    if (!rx_level && !meas && !speed_match_enable && tick) begin
                        rx_state <= RX_START;
                        rx_ph <= '0;
                    end
                end
                RX_START: begin
                    if (tick) begin
                        rx_ph <= rx_ph + 4'h1;
                        if (rx_ph == PH_MID && rx_level) begin
                            rx_state <= RX_IDLE; // glitch, not a start
                        end else if (rx_ph == PH_LAST) begin
                            rx_state <= RX_DATA;
                            rx_bit <= '0;
                        end
                    end
                end
                RX_DATA: begin
                    if (tick) begin
                        rx_ph <= rx_ph + 4'h1;
                        if (rx_ph == PH_MID) begin
                            rx_sh <= {rx_level, rx_sh[7:1]};
                        end
                        if (rx_ph == PH_LAST) begin
                            rx_bit <= rx_bit + 3'h1;
                            if (rx_bit == BIT_LAST) begin
                                rx_state <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (tick) begin
                        rx_ph <= rx_ph + 4'h1;
                        if (rx_ph == PH_MID) begin
                            rx_state <= (!rx_level && rx_sh == '0) ? RX_BRK_WAIT : RX_IDLE;
                        end
                    end
                end
                RX_BRK_WAIT: begin
                    // first one after a break is not a stop bit
                    if (tick) begin
                        rx_ph <= rx_ph + 4'h1;
                        if (rx_ph == PH_MID && rx_level) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    assign rx_done = (rx_state == RX_STOP) && tick && (rx_ph == PH_MID);

    // received byte and error flags
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= '0;
            rx_full <= 1'b0;
            frame_err <= 1'b0;
        end else if (rx_done && !(!rx_level && rx_sh == '0)) begin
            rx_data <= rx_sh;
            rx_full <= 1'b1;
            frame_err <= ~rx_level; // bad stop still loads
        end else if (rd_ok && reg_addr == RR_RXDATA) begin
            rx_full <= 1'b0;
            frame_err <= 1'b0;
        end
    end

    // break flag: a received one is the only way out
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            break_detected_flag <= 1'b0;
        end else if (brk_hit || (rx_done && !rx_level && rx_sh == '0)) begin
            break_detected_flag <= 1'b1;
        end else if (rx_state == RX_BRK_WAIT && tick && rx_ph == PH_MID && rx_level) begin
            break_detected_flag <= 1'b0;
        end
    end

    // byte or break interrupt, dropped when data is read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_pend <= 1'b0;
        end else if ((rx_done && rx_level && irq_sel != SEL_SPEED) || (brk_hit && brk_irq_en)) begin
            rx_pend <= 1'b1;
        end else if (rd_ok && reg_addr == RR_RXDATA) begin
            rx_pend <= 1'b0;
        end
    end

    // pin follows the flags one cycle later
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            receive_interrupt_output_n <= 1'b1;
            receive_interrupt_output_oe <= 1'b0;
        end else begin
            receive_interrupt_output_n <= ~(sm_irq | rx_pend);
            receive_interrupt_output_oe <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // transmitter, single holding byte
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_hold <= '0;
            tx_full <= 1'b0;
            tx_busy <= 1'b0;
            tx_sh <= '1;
            tx_ph <= '0;
            tx_cnt <= '0;
        end else if (transmit_abort) begin
            tx_full <= 1'b0;
            tx_busy <= 1'b0;
            tx_sh <= '1;
        end else begin
            if (!tx_busy && tx_full && tick) begin
                tx_sh <= {1'b1, tx_hold, 1'b0};
                tx_full <= 1'b0;
                tx_busy <= 1'b1;
                tx_ph <= '0;
                tx_cnt <= '0;
            end else if (tx_busy && tick) begin
                tx_ph <= tx_ph + 4'h1;
                if (tx_ph == PH_LAST) begin
                    tx_sh <= {1'b1, tx_sh[9:1]};
                    tx_cnt <= tx_cnt + 4'h1;
                    tx_busy <= (tx_cnt != TX_LAST);
                end
            end
            // a new byte landing as the old one starts must not be lost
            if (wr_ok && reg_addr == WR_TXDATA) begin
                tx_hold <= reg_wdata;
                tx_full <= 1'b1;
            end
        end
    end

    // line idles high, released in reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_pin <= 1'b1;
            tx_pin_oe <= 1'b0;
        end else begin
            tx_pin <= tx_busy ? tx_sh[0] : 1'b1;
            tx_pin_oe <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // read data, valid only the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rdata_oe <= 1'b0;
        end else begin
            reg_rdata_oe <= rd_ok;
            if (rd_ok) begin
                case (reg_addr)
                    RR_RXDATA: reg_rdata <= rx_data;
                    RR_STATUS: reg_rdata <= {2'b00, speed_match_enable, test_a, tx_busy,
                                            tx_full, rx_full, receive_interrupt_output_n};
                    RR_ERROR: reg_rdata <= {4'h0, sm_irq, short_pulse, frame_err, break_detected_flag};
                    RR_DIVLO: reg_rdata <= divisor[7:0];
                    RR_DIVHI: reg_rdata <= divisor[15:8];
                    default: reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_good_end;
        meas && rx_rise;
    endsequence
    sequence s_break;
        meas && !rx_level && (low_count > BREAK_LIMIT);
    endsequence

    property p_smen_clear;
        rx_fall |=> !speed_match_enable;
    endproperty
    a_smen_clear: assert property (p_smen_clear) else $error("enable not cleared");

    property p_load;
        s_good_end |=> divisor == count_to_div($past(low_count));
    endproperty
    a_load: assert property (p_load) else $error("divisor not loaded");

    property p_read_div;
        (rd_ok && reg_addr == RR_DIVLO) |=> reg_rdata_oe && reg_rdata == $past(divisor[7:0]);
    endproperty
    a_read_div: assert property (p_read_div) else $error("divisor read wrong");

    property p_sm_irq;
        (s_good_end and (irq_sel == SEL_SPEED)) |=> sm_irq ##1 !receive_interrupt_output_n;
    endproperty
    a_sm_irq: assert property (p_sm_irq) else $error("match interrupt missing");

    property p_irq_hold;
        (sm_irq && !(wr_ok && reg_addr == WR_MODE)) |=> sm_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");

    property p_break;
        s_break |=> break_detected_flag && !meas && rx_state == RX_BRK_WAIT;
    endproperty
    a_break: assert property (p_break) else $error("break not declared");

    property p_no_load;
        s_break |=> $stable(divisor) && !$rose(sm_irq);
    endproperty
    a_no_load: assert property (p_no_load) else $error("break changed divisor");

    property p_zero_div;
        (divisor == '0 && !good_end) |=> $stable(rx_ph) && $stable(tx_ph);
    endproperty
    a_zero_div: assert property (p_zero_div) else $error("tick with zero divisor");

    property p_irq_pin;
        $rose(rx_pend) |=> !receive_interrupt_output_n;
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not low");

endmodule : uart_speed_match

// File: serial_sender.sv
`timescale 1ns/100ps
module serial_sender (
    input wire logic clk_sys,
    output logic rx_pin
);
    // line idles high until the first character starts
    initial begin
        rx_pin = 1'b1;
    end

    // first low pulse, taken by the far end as one start bit
    task automatic low(input int n);
        rx_pin <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask : low

    // give the line back; drives it high to idle
    task automatic rel();
        rx_pin <= 1'b1;
    endtask : rel

    // data bits LSB first, then one stop bit at the same rate
    task automatic bits(input logic [7:0] d, input int per);
        for (int i = 0; i < 8; i++) begin
            rx_pin <= d[i];
            repeat (per) @(posedge clk_sys);
        end
        rx_pin <= 1'b1;
        repeat (per) @(posedge clk_sys);
    endtask : bits
endmodule : serial_sender

// File: tb_uart_speed_match.sv
`timescale 1ns/100ps
module tb_uart_speed_match;
    import speed_match_pkg::*;
    logic clk_sys, rst_n, chip_sel, reg_wr, reg_rd, nocs;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rdv;
    logic reg_rdata_oe, tx_pin, tx_pin_oe, irq_n, irq_oe, rx_pin, oev;
    int failures = 0;
    int checked = 0;
    int n;

    // short break limit keeps the overlong pulse cheap to simulate
    uart_speed_match #(.BREAK_LIMIT(16'h0100)) uart_speed_match_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .chip_sel(chip_sel), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rdata_oe(reg_rdata_oe), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe),
        .receive_interrupt_output_n(irq_n), .receive_interrupt_output_oe(irq_oe));
    serial_sender serial_sender_inst (.clk_sys(clk_sys), .rx_pin(rx_pin));

    // ----------------------------------------
    // bus access and comparison
    // ----------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // extra edge after each strobe so no task re-drives it in the same step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        chip_sel <= !nocs;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        chip_sel <= 1'b0;
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        chip_sel <= 1'b1;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        chip_sel <= 1'b0;
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
        oev = reg_rdata_oe;
        @(posedge clk_sys);
    endtask : rd

    task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        rd(a);
        chk({7'h00, oev}, 8'h01);
        chk(rdv & m, e);
    endtask : rc

    task automatic irq(input logic e);
        chk({7'h00, irq_n}, {7'h00, e});
    endtask : irq

    task automatic conclude();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // ----------------------------------------
    // clock and scenarios
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        rst_n = 1'b0;
        chip_sel = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        nocs = 1'b0;
        repeat (12) @(posedge clk_sys);
        chk({5'h00, reg_rdata_oe, tx_pin_oe, irq_oe}, 8'h00);
        chk({6'h00, tx_pin, irq_n}, 8'h03);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({6'h00, tx_pin_oe, irq_oe}, 8'h03);
        rc(RR_DIVLO, 8'h01);
        rc(RR_DIVHI, 8'h00);
        rc(RR_STATUS, 8'h01);
        rc(RR_RXDATA, 8'h00);
        wr(WR_TEST, 8'h00);
        rc(RR_STATUS, 8'h00, 8'h10);
        rc(RR_ERROR, 8'h00);
        rc(4'hF, 8'h00);
        nocs = 1'b1;
        wr(WR_DIVLO, 8'h33);
        nocs = 1'b0;
        rc(RR_DIVLO, 8'h01);
        // good pulse: 168 clocks gives 10 whatever the one-clock jitter
        wr(WR_IRQSEL, 8'h00);
        wr(WR_MODE, 8'h28);
        rc(RR_STATUS, 8'h20, 8'h20);
        serial_sender_inst.low(168);
        fork
            serial_sender_inst.bits(8'hA5, 160);
            begin
                repeat (6) @(posedge clk_sys);
                rc(RR_DIVLO, 8'h0A);
                rc(RR_DIVHI, 8'h00);
                rc(RR_STATUS, 8'h00, 8'h21);
                rc(RR_ERROR, 8'h08, 8'h09);
                irq(1'b0);
                wr(WR_DIVLO, 8'h0A);
            end
        join
        rc(RR_RXDATA, 8'hA5);
        irq(1'b0);
        wr(WR_MODE, 8'h20);
        repeat (2) @(posedge clk_sys);
        irq(1'b1);
        // short pulse with the match interrupt not selected
        wr(WR_IRQSEL, 8'h08);
        wr(WR_MODE, 8'h28);
        serial_sender_inst.low(40);
        serial_sender_inst.rel();
        repeat (6) @(posedge clk_sys);
        rc(RR_DIVLO, 8'h02);
        rc(RR_ERROR, 8'h04, 8'h0C);
        repeat (400) @(posedge clk_sys);
        rc(RR_RXDATA, 8'hFF);
        // very short pulse loads zero and stalls the transmitter
        wr(WR_IRQSEL, 8'h00);
        wr(WR_MODE, 8'h08);
        serial_sender_inst.low(10);
        serial_sender_inst.rel();
        repeat (6) @(posedge clk_sys);
        rc(RR_DIVLO, 8'h00);
        rc(RR_ERROR, 8'h0C, 8'h0C);
        wr(WR_MODE, 8'h00);
        wr(WR_TXDATA, 8'h55);
        repeat (300) @(posedge clk_sys);
        chk({7'h00, tx_pin}, 8'h01);
        wr(WR_DIVLO, 8'h01);
        for (n = 0; n < 200 && tx_pin !== 1'b0; n++)
            @(posedge clk_sys);
        chk({7'h00, tx_pin}, 8'h00);
        repeat (300) @(posedge clk_sys);
        rd(RR_RXDATA);
        // overlong pulse: break with its interrupt enabled, divisor kept
        wr(WR_IRQSEL, 8'h40);
        wr(WR_MODE, 8'h08);
        serial_sender_inst.low(300);
        rc(RR_ERROR, 8'h01, 8'h09);
        rc(RR_DIVLO, 8'h01);
        irq(1'b0);
        serial_sender_inst.rel();
        repeat (100) @(posedge clk_sys);
        rc(RR_ERROR, 8'h00, 8'h09);
        rd(RR_RXDATA);
        repeat (2) @(posedge clk_sys);
        irq(1'b1);
        conclude();
    end
endmodule : tb_uart_speed_match
